// ### serdes_rx_cdr_pipe_control_tb.sv
`timescale 1ns/1ps
`include "srx_map.svh"
`default_nettype none

module serdes_rx_cdr_pipe_control_tb;
  import srx_pkg::*;
  logic sys_clk, reset_n, cfg_basic_8b10b, cfg_pipe_mode, cfg_gigabit_ethernet_mode, cfg_manual_align;
  logic [7:0] line_level, sig_threshold;
  logic line_rx_present, slip_req, fifo_push, fifo_pop, reg_wr, reg_rd;
  logic tx_disp_negative, reverse_loopback, recov_clk_en, irq, fabric_rd_en;
  logic [9:0] code_group_in, decoder_in;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rs, d, c;
  int failures, total_checks, n, k, es, i, j;
  srx_link_if link();
  srx_device srx_device_inst(.sys_clk(sys_clk), .reset_n(reset_n), .link(link), .cfg_basic_8b10b(cfg_basic_8b10b),
    .cfg_pipe_mode(cfg_pipe_mode), .cfg_gigabit_ethernet_mode(cfg_gigabit_ethernet_mode),
    .cfg_manual_align(cfg_manual_align),
    .line_level(line_level), .sig_threshold(sig_threshold), .line_rx_present(line_rx_present), .slip_req(slip_req),
    .fifo_push(fifo_push), .fifo_pop(fifo_pop), .code_group_in(code_group_in), .decoder_in(decoder_in),
    .tx_disp_negative(tx_disp_negative), .reverse_loopback(reverse_loopback), .recov_clk_en(recov_clk_en),
    .fabric_rd_en(fabric_rd_en));
  srx_host srx_host_inst(.sys_clk(sys_clk), .reset_n(reset_n), .link(link), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  srx_asserts srx_asserts_inst(.sys_clk(sys_clk), .reset_n(reset_n), .force_data_lock(link.force_data_lock),
    .force_ref_lock(link.force_ref_lock), .detect_loop_req(link.detect_loop_req), .force_tx_idle(link.force_tx_idle),
    .power_state(link.power_state), .data_lock(link.data_lock), .fifo_fault(link.fifo_fault),
    .slip_count_out(link.slip_count_out), .phy_done(link.phy_done), .rx_detected(link.rx_detected));
  ////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [9:0] exp_dec(input logic [9:0] g, input logic inv);
    return inv ? ~g : g;
  endfunction
  function automatic logic exp_lock(input logic [1:0] p);
    return p[1] | (p == 2'b00);
  endfunction
  task automatic tick(input int m);
    repeat (m) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Bounded wait; n keeps the cycle count for timing checks
  task automatic wdone();
    for (n = 1; n < 300 && link.phy_done !== 1'b1; n++)
      tick(1);
    if (n == 300)
    begin
      failures++;
      summarize();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    {reset_n, cfg_basic_8b10b, cfg_gigabit_ethernet_mode, cfg_manual_align, line_rx_present, slip_req} = '0;
    {fifo_push, fifo_pop, reg_wr, reg_rd, reg_addr, reg_wdata, line_level, sig_threshold, code_group_in} = '0;
    cfg_pipe_mode = 1'b1;
    rs = 32'h03D98E44;
    c = '0;
    es = 0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    tick(2);
    chk("fault", 1, 32'(link.fifo_fault));
    rd(`SRX_REG_CTRL, d);
    chk("ctrl", 0, d);
    rd(`SRX_REG_IRQ_ENABLE, d);
    chk("irq_en", 0, d);
    rd(5'h1C, d);
    chk("unmapped", 0, d);
    for (i = 0; i < 8; i++)
    begin
      rs = nxt(rs);
      @(posedge sys_clk);
      code_group_in <= rs[9:0];
      c[`SRX_CTRL_INVERT] = rs[10];
      wr(`SRX_REG_CTRL, c);
      tick(6);
      chk("decoder", 32'(exp_dec(rs[9:0], rs[10])), 32'(decoder_in));
    end
    for (i = 0; i < 8; i++)
    begin
      rs = nxt(rs);
      @(posedge sys_clk);
      line_level <= rs[7:0];
      sig_threshold <= (i == 0) ? rs[7:0] : rs[15:8];
      tick(5);
      chk("sig", 32'(rs[7:0] > ((i == 0) ? rs[7:0] : rs[15:8])), 32'(link.signal_present));
    end
    line_level <= 8'hFF;
    sig_threshold <= 8'h00;
    for (j = 0; j < 4; j++)
    begin
      {cfg_basic_8b10b, cfg_pipe_mode} <= 2'(j);
      tick(5);
      chk("sig_mode", 32'(j != 0), 32'(link.signal_present));
    end
    for (j = 0; j < 4; j++)
    begin
      c[1:0] = 2'(j);
      wr(`SRX_REG_CTRL, c);
      tick(60);
      rd(`SRX_REG_STATUS, d);
      chk("lock", 32'(exp_lock({c[`SRX_CTRL_DATA_LOCK], c[`SRX_CTRL_REF_LOCK]})), 32'(d[0]));
    end
    c[1:0] = 2'b00;
    cfg_manual_align <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      rs = nxt(rs);
      for (k = 0; k < rs[3:0]; k++)
      begin
        @(posedge sys_clk);
        slip_req <= 1'b1;
        @(posedge sys_clk);
        slip_req <= 1'b0;
      end
      es = (es + rs[3:0]) % 10;
      tick(5);
      chk("slip", es, 32'(link.slip_count_out));
    end
    wr(`SRX_REG_CMD, 32'h2);
    for (k = 0, n = 0; k < 10; k++)
    begin
      tick(1);
      n += (tx_disp_negative === 1'b1);
    end
    chk("compliance", 1, n);
    wr(`SRX_REG_CMD, 32'h1);
    tick(8);
    chk("loopback", 1, 32'(reverse_loopback));
    c[4:2] = {`SRX_PS_P1, 1'b1};
    wr(`SRX_REG_CTRL, c);
    wdone();
    tick(150);
    chk("loopback_off", 0, 32'(reverse_loopback));
    wr(`SRX_REG_IRQ_CLEAR, 32'h7);
    wr(`SRX_REG_IRQ_ENABLE, 32'h1);
    for (i = 1; i >= 0; i--)
    begin
      @(posedge sys_clk);
      line_rx_present <= 1'(i);
      wr(`SRX_REG_CMD, 32'h1);
      wdone();
      tick(2);
      chk("req_drop", 0, 32'(link.detect_loop_req));
      chk("irq", 1, 32'(irq));
      rd(`SRX_REG_STATUS, d);
      chk("detected", i, 32'(d[2]));
      wr(`SRX_REG_IRQ_CLEAR, 32'h1);
      tick(3);
      chk("irq_clear", 0, 32'(irq));
    end
    for (j = 1; j < 4; j++)
    begin
      c[4:3] = (j == 1) ? `SRX_PS_P0S : ((j == 2) ? `SRX_PS_P2 : `SRX_PS_P0);
      wr(`SRX_REG_CTRL, c);
      wdone();
      chk("ps_time", 1, 32'(n >= 20 && n <= 30));
    end
    wr(`SRX_REG_IRQ_CLEAR, 32'h1);
    // Fill to full, then drain to empty; fault flags both ends
    for (j = 0; j < 2; j++)
      for (i = 0; i < 8; i++)
      begin
        @(posedge sys_clk);
        {fifo_push, fifo_pop} <= (j == 0) ? 2'b10 : 2'b01;
        @(posedge sys_clk);
        {fifo_push, fifo_pop} <= 2'b00;
        tick(4);
        chk("fifo_fault", 32'(i == 7), 32'(link.fifo_fault));
      end
    chk("irq_masked", 0, 32'(irq));
    rd(`SRX_REG_IRQ_STATUS, d);
    chk("irq_status", 32'h2, d);
    for (j = 0; j < 2; j++)
    begin
      cfg_gigabit_ethernet_mode <= 1'(j);
      tick(8);
      for (k = 0, n = 0; k < 16; k++)
      begin
        tick(1);
        n += (recov_clk_en === 1'b1);
      end
      chk("recov", 4 * j, n);
    end
    chk("fabric_rd", 0, 32'(fabric_rd_en));
    summarize();
  end
endmodule

`default_nettype wire

// ### srx_asserts.sv
`timescale 1ns/1ps
`include "srx_map.svh"
`default_nettype none

module srx_asserts
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic force_data_lock,
  input wire logic force_ref_lock,
  input wire logic detect_loop_req,
  input wire logic force_tx_idle,
  input wire logic [1:0] power_state,
  input wire logic data_lock,
  input wire logic fifo_fault,
  input wire srx_pkg::srx_slip_t slip_count_out,
  input wire logic phy_done,
  input wire logic rx_detected
);
  import srx_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////
  // Detection is only legal in P1 with idle forced
  sequence s_det_start;
    $rose(detect_loop_req) && power_state == `SRX_PS_P1 && force_tx_idle;
  endsequence
  // Sixteen calibration ticks plus sync, with room for a queued state change
  sequence s_done_seen;
    ##[1:200] phy_done;
  endsequence
  ////////////////////////////////////////////////////////////////
  a_done_one_cycle: assert property (phy_done |=> !phy_done)
    else $error("done pulse longer than one cycle");
  a_slip_range: assert property (slip_count_out <= `SRX_SLIP_TOP)
    else $error("slip count above nine");
  a_lock_data_forced: assert property (force_data_lock [*5] |-> data_lock)
    else $error("data lock missing while forced");
  a_lock_ref_forced: assert property ((!force_data_lock && force_ref_lock) [*5] |-> !data_lock)
    else $error("data lock high while reference forced");
  a_detect_gets_done: assert property (s_det_start |-> s_done_seen)
    else $error("detection never completed");
  a_req_drop_done: assert property ((phy_done && power_state == `SRX_PS_P1 && force_tx_idle) |=> !detect_loop_req)
    else $error("request held after done");
  a_ps_done_time: assert property ($changed(power_state) |-> ##[21:40] phy_done)
    else $error("power state change not acknowledged in time");
  a_fault_empty_reset: assert property ($rose(reset_n) |-> fifo_fault)
    else $error("fault flag low with empty fifo");
  a_detect_result_done: assert property ($changed(rx_detected) |-> phy_done)
    else $error("detect result moved without done");
endmodule

`default_nettype wire

// ### srx_device.sv
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "srx_map.svh"
`default_nettype none

module srx_device
#(
  parameter int FIFO_DEPTH = 8,
  parameter int RECOV_DIV = 4,
  parameter int FABRIC_RD_DIV = 2,
  parameter bit USE_FABRIC_RD = 1'b0
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  srx_link_if.dev link,
  input wire logic cfg_basic_8b10b,
  input wire logic cfg_pipe_mode,
  input wire logic cfg_gigabit_ethernet_mode,
  input wire logic cfg_manual_align,
  input wire logic [7:0] line_level,
  input wire logic [7:0] sig_threshold,
  input wire logic line_rx_present,
  input wire logic slip_req,
  input wire logic fifo_push,
  input wire logic fifo_pop,
  input wire logic [9:0] code_group_in,
  output logic [9:0] decoder_in,
  output logic tx_disp_negative,
  output logic reverse_loopback,
  output logic recov_clk_en,
  output logic fabric_rd_en
);
  import srx_pkg::*;

  localparam int NSYNC = 9;
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [7:0] PS_CYC = 8'(`SRX_PS_CYCLES);
  localparam logic [7:0] REF_CYC = 8'(`SRX_REF_LOCK_CYCLES);
  localparam logic [7:0] DET_TICKS = 8'(`SRX_DET_TICKS);

  logic [NSYNC-1:0] sync_a, sync_b;
  logic s_data_lock, s_ref_lock, s_req, s_idle, s_comp, s_inv, s_cal, rd_strobe, sig_ok;
  logic [1:0] s_ps, ps_last;
  srx_state_e state;
  logic [7:0] cnt, ref_cnt, recov_div, rd_div;
  logic [CW-1:0] fill;
  srx_lock_e lock_mode;

  function automatic logic [7:0] wrap_inc(input logic [7:0] v, input int lim);
    wrap_inc = (v >= 8'(lim - 1)) ? 8'h00 : v + 8'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control synchronisers
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= {link.force_data_lock, link.force_ref_lock, link.detect_loop_req, link.force_tx_idle,
                 link.power_state, link.compliance_negative_disp, link.decoder_input_invert,
                 link.cal_tick};
      sync_b <= sync_a;
    end
  end

  assign {s_data_lock, s_ref_lock, s_req, s_idle, s_ps, s_comp, s_inv, s_cal} = sync_b;

  ////////////////////////////////////////////////////////////////////////////
  // Clock recovery lock; data wins over reference
  assign lock_mode = s_data_lock ? SRX_LOCK_DATA : (s_ref_lock ? SRX_LOCK_REF : SRX_LOCK_AUTO);
  assign sig_ok = (cfg_basic_8b10b || cfg_pipe_mode) && (line_level > sig_threshold);
  // Auto mode: once signal seen, settle on reference for REF_CYC cycles, then move to data; losing signal restarts the count
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      ref_cnt <= 8'h00;
    else if (lock_mode != SRX_LOCK_AUTO || !sig_ok)
      ref_cnt <= 8'h00;
    else if (ref_cnt != REF_CYC)
      ref_cnt <= ref_cnt + 8'h01;
  end
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      link.data_lock <= 1'b0;
    else
      link.data_lock <= (lock_mode == SRX_LOCK_DATA) ||
                        (lock_mode == SRX_LOCK_AUTO && sig_ok && ref_cnt == REF_CYC);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      link.signal_present <= 1'b0;
    else
      link.signal_present <= sig_ok;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase compensation FIFO occupancy
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rd_div <= 8'h00;
    else
      rd_div <= wrap_inc(rd_div, FABRIC_RD_DIV);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      fabric_rd_en <= 1'b0;
    else
      fabric_rd_en <= USE_FABRIC_RD && (rd_div == 8'h00);
  end

  // Pops only on the fabric strobe when the separate read side is used
  assign rd_strobe = fifo_pop && (!USE_FABRIC_RD || fabric_rd_en) && (fill != '0);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      fill <= '0;
    else if (fifo_push && fill != CW'(FIFO_DEPTH) && !rd_strobe)
      fill <= fill + 1'b1;
    else if (rd_strobe && !(fifo_push && fill != CW'(FIFO_DEPTH)))
      fill <= fill - 1'b1;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      link.fifo_fault <= 1'b1;
    else
      link.fifo_fault <= (fill == '0) || (fill == CW'(FIFO_DEPTH));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word aligner slip count
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      link.slip_count_out <= 4'h0;
    else if (!cfg_manual_align)
      link.slip_count_out <= 4'h0;
    else if (slip_req)
      link.slip_count_out <= (link.slip_count_out == `SRX_SLIP_TOP) ? 4'h0 : link.slip_count_out + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Detection and power state sequencing
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= SRX_IDLE;
      cnt <= 8'h00;
      ps_last <= `SRX_PS_P0;
      link.phy_done <= 1'b0;
      link.rx_detected <= 1'b0;
    end
    else
    begin
      link.phy_done <= 1'b0;
      case (state)
        SRX_IDLE:
        begin
          cnt <= 8'h00;
          if (s_ps != ps_last)
          begin
            ps_last <= s_ps;
            state <= SRX_PS_WAIT;
          end
          else if (s_req && s_ps == `SRX_PS_P1 && s_idle)
            state <= SRX_DETECT;
        end
        SRX_DETECT:
        begin
          // Counts calibration ticks only
          if (s_cal)
            cnt <= cnt + 8'h01;
          if (s_cal && cnt == DET_TICKS - 8'h01)
          begin
            link.rx_detected <= line_rx_present;
            link.phy_done <= 1'b1;
            state <= SRX_HOLD;
          end
        end
        SRX_PS_WAIT:
        begin
          cnt <= cnt + 8'h01;
          if (cnt == PS_CYC - 8'h01)
          begin
            link.phy_done <= 1'b1;
            state <= SRX_IDLE;
          end
        end
        SRX_HOLD:
        begin
          // Wait for request to drop so one request gives one detection
          if (!s_req)
            state <= SRX_IDLE;
        end
        default: state <= SRX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      reverse_loopback <= 1'b0;
    else
      reverse_loopback <= s_req && s_ps == `SRX_PS_P0 && !s_idle;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Encoder and decoder controls
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_disp_negative <= 1'b0;
      decoder_in <= 10'h000;
    end
    else
    begin
      tx_disp_negative <= s_comp;
      decoder_in <= s_inv ? ~code_group_in : code_group_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Recovered clock enable
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      recov_div <= 8'h00;
      recov_clk_en <= 1'b0;
    end
    else
    begin
      recov_div <= wrap_inc(recov_div, RECOV_DIV);
      recov_clk_en <= cfg_gigabit_ethernet_mode && (recov_div == 8'h00);
    end
  end

endmodule

`default_nettype wire

// ### srx_host.sv
`timescale 1ns/1ps
`include "srx_map.svh"
`default_nettype none

module srx_host
#(
  parameter int CAL_DIV = 4
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  srx_link_if.mac link,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  import srx_pkg::*;

  logic [5:0] ctrl;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic [2:0] events;
  logic [7:0] cal_div;
  logic fault_last;
  logic lock_last;
  logic wr_cmd;

  assign wr_cmd = reg_wr && reg_addr == `SRX_REG_CMD;

  ////////////////////////////////////////////////////////////////////////////
  // Control register and link drive
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl <= `SRX_CTRL_RESET;
    else if (reg_wr && reg_addr == `SRX_REG_CTRL)
      ctrl <= reg_wdata[5:0];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link.force_data_lock <= 1'b0;
      link.force_ref_lock <= 1'b0;
      link.force_tx_idle <= 1'b0;
      link.power_state <= `SRX_PS_P0;
      link.decoder_input_invert <= 1'b0;
    end
    else
    begin
      link.force_data_lock <= ctrl[`SRX_CTRL_DATA_LOCK];
      link.force_ref_lock <= ctrl[`SRX_CTRL_REF_LOCK];
      link.force_tx_idle <= ctrl[`SRX_CTRL_TX_IDLE];
      link.power_state <= ctrl[`SRX_CTRL_PS_LO +: 2];
      link.decoder_input_invert <= ctrl[`SRX_CTRL_INVERT];
    end
  end

  // Request stays up until the done pulse; done wins over a new write
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      link.detect_loop_req <= 1'b0;
    else if (link.phy_done)
      link.detect_loop_req <= 1'b0;
    else if (wr_cmd && reg_wdata[`SRX_CMD_DETECT])
      link.detect_loop_req <= 1'b1;
  end

  // One cycle stands for the first compliance byte
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      link.compliance_negative_disp <= 1'b0;
    else
      link.compliance_negative_disp <= wr_cmd && reg_wdata[`SRX_CMD_COMPLIANCE];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cal_div <= 8'h00;
      link.cal_tick <= 1'b0;
    end
    else
    begin
      cal_div <= (cal_div >= 8'(CAL_DIV - 1)) ? 8'h00 : cal_div + 8'h01;
      link.cal_tick <= (cal_div == 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fault_last <= 1'b0;
      lock_last <= 1'b0;
    end
    else
    begin
      fault_last <= link.fifo_fault;
      lock_last <= link.data_lock;
    end
  end

  assign events = {link.data_lock != lock_last, link.fifo_fault && !fault_last, link.phy_done};

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_status <= `SRX_IRQ_RESET;
    else if (reg_wr && reg_addr == `SRX_REG_IRQ_CLEAR)
      irq_status <= (irq_status & ~reg_wdata[2:0]) | events;
    else
      irq_status <= irq_status | events;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_enable <= `SRX_IRQ_RESET;
    else if (reg_wr && reg_addr == `SRX_REG_IRQ_ENABLE)
      irq_enable <= reg_wdata[2:0];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_enable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SRX_REG_CTRL: reg_rdata <= {26'h0, ctrl};
        `SRX_REG_STATUS: reg_rdata <= {24'h0, link.slip_count_out, link.detect_loop_req,
                                       link.rx_detected, link.signal_present, link.data_lock};
        `SRX_REG_IRQ_STATUS: reg_rdata <= {29'h0, irq_status};
        `SRX_REG_IRQ_ENABLE: reg_rdata <= {29'h0, irq_enable};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule

`default_nettype wire

// ### srx_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface srx_link_if;
  logic force_data_lock;
  logic force_ref_lock;
  logic detect_loop_req;
  logic force_tx_idle;
  logic [1:0] power_state;
  logic compliance_negative_disp;
  logic decoder_input_invert;
  logic cal_tick;
  logic data_lock;
  logic signal_present;
  logic fifo_fault;
  srx_pkg::srx_slip_t slip_count_out;
  logic phy_done;
  logic rx_detected;

  modport dev
  (
    input force_data_lock, force_ref_lock, detect_loop_req, force_tx_idle, power_state,
    input compliance_negative_disp, decoder_input_invert, cal_tick,
    output data_lock, signal_present, fifo_fault, slip_count_out, phy_done, rx_detected
  );

  modport mac
  (
    output force_data_lock, force_ref_lock, detect_loop_req, force_tx_idle, power_state,
    output compliance_negative_disp, decoder_input_invert, cal_tick,
    input data_lock, signal_present, fifo_fault, slip_count_out, phy_done, rx_detected
  );
endinterface

`default_nettype wire

// ### srx_map.svh
`ifndef SRX_MAP_SVH
`define SRX_MAP_SVH

// Clock rate
`define SRX_CLK_MHZ 40

// Power state encodings
`define SRX_PS_P0 2'b00
`define SRX_PS_P0S 2'b01
`define SRX_PS_P1 2'b10
`define SRX_PS_P2 2'b11

// Word aligner slip range
`define SRX_SLIP_TOP 4'h9

// Timing, least times rounded up to whole cycles
`define SRX_PS_TIME_NS 500
`define SRX_PS_CYCLES ((`SRX_PS_TIME_NS * `SRX_CLK_MHZ + 999) / 1000)
`define SRX_REF_LOCK_NS 1000
`define SRX_REF_LOCK_CYCLES ((`SRX_REF_LOCK_NS * `SRX_CLK_MHZ + 999) / 1000)
`define SRX_DET_TICKS 16

// Controller register offsets
`define SRX_REG_CTRL 5'h00
`define SRX_REG_CMD 5'h04
`define SRX_REG_STATUS 5'h08
`define SRX_REG_IRQ_STATUS 5'h0C
`define SRX_REG_IRQ_CLEAR 5'h10
`define SRX_REG_IRQ_ENABLE 5'h14

// Field positions
`define SRX_CTRL_DATA_LOCK 0
`define SRX_CTRL_REF_LOCK 1
`define SRX_CTRL_TX_IDLE 2
`define SRX_CTRL_PS_LO 3
`define SRX_CTRL_INVERT 5
`define SRX_CMD_DETECT 0
`define SRX_CMD_COMPLIANCE 1
`define SRX_IRQ_DONE 0
`define SRX_IRQ_FAULT 1
`define SRX_IRQ_LOCK 2

// Reset values
`define SRX_CTRL_RESET 6'h00
`define SRX_IRQ_RESET 3'h0

`endif

// ### srx_pkg.sv
`default_nettype none

package srx_pkg;

  typedef enum logic [1:0]
  {
    SRX_LOCK_AUTO = 2'b00,
    SRX_LOCK_REF = 2'b01,
    SRX_LOCK_DATA = 2'b10
  } srx_lock_e;

  typedef enum logic [1:0]
  {
    SRX_IDLE = 2'b00,
    SRX_DETECT = 2'b01,
    SRX_PS_WAIT = 2'b10,
    SRX_HOLD = 2'b11
  } srx_state_e;

  typedef logic [3:0] srx_slip_t;

endpackage

`default_nettype wire
